/* File: rtl/compare_slot.sv */
`timescale 1ns/1ps
`default_nettype none

module compare_slot #(
    parameter logic [7:0] HI_RESET = 8'h00,
    parameter logic [7:0] LO_RESET = 8'h00,
    parameter logic [7:0] HI_MASK  = 8'hFF,
    parameter logic [7:0] LO_MASK  = 8'hFF
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       wr_hi,
    input  wire logic       wr_lo,
    input  wire logic [7:0] wdata,
    input  wire logic       load,
    output logic [7:0]      act_hi,
    output logic [7:0]      act_lo
);
    import pwm_chopper_pkg::*;

    slot_state_t s;
    slot_state_t n;

    always_comb begin
        n = s;
        if (load && s.pair_done) begin
            n.act_hi = s.pre_hi;                                       // R11
            n.act_lo = s.pre_lo;
        end
        // high byte first, low byte completes the pair
        if (wr_hi) begin
            n.pre_hi    = wdata & HI_MASK;                             // R16
            n.hi_done   = 1'b1;
            n.pair_done = 1'b0;
        end
        if (wr_lo) begin
            n.pre_lo    = wdata & LO_MASK;                             // R15
            n.pair_done = s.hi_done;                                   // R17
            n.hi_done   = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '{pre_hi: HI_RESET, pre_lo: LO_RESET, hi_done: 1'b0, pair_done: 1'b0,
                   act_hi: HI_RESET, act_lo: LO_RESET};
        end else begin
            s <= n;
        end
    end

    assign act_hi = s.act_hi;
    assign act_lo = s.act_lo;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    pair_gate_a: assert property (load && !s.pair_done |=> $stable(act_hi) && $stable(act_lo)) // R17
        else $error("half written compare was transferred");
    slot_transfer_a: assert property (load && s.pair_done |=> act_hi == $past(s.pre_hi)) // R11
        else $error("complete compare not transferred");
    reserved_low_a: assert property (wr_lo |=> (s.pre_lo & ~LO_MASK) == 8'h00) // R15
        else $error("reserved compare bits stored");

endmodule

`default_nettype wire

/* File: rtl/pwm_chopper_pkg.sv */
package pwm_chopper_pkg;

    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 8;
    localparam int CNT_W      = 12;
    localparam int CMP_W      = 13;
    localparam int NUM_PHASES = 3;
    localparam int NUM_SLOTS  = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_REF  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_REP  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_WH   = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_WL   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_VH   = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_VL   = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_UH   = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_UL   = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_P0H  = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_P0L  = 4'hA;
    localparam logic [ADDR_W-1:0] ADDR_RUN  = 4'hB;

    // slot order: phase u, phase v, phase w, compare 0
    localparam int SLOT_P0 = 3;
    localparam logic [ADDR_W-1:0] SLOT_HI_ADDR [NUM_SLOTS] = '{ADDR_UH, ADDR_VH, ADDR_WH, ADDR_P0H};
    localparam logic [ADDR_W-1:0] SLOT_LO_ADDR [NUM_SLOTS] = '{ADDR_UL, ADDR_VL, ADDR_WL, ADDR_P0L};
    localparam logic [7:0] SLOT_HI_RESET [NUM_SLOTS] = '{8'h00, 8'h00, 8'h00, 8'h0F};
    localparam logic [7:0] SLOT_LO_RESET [NUM_SLOTS] = '{8'h00, 8'h00, 8'h00, 8'hFF};
    localparam logic [7:0] SLOT_HI_MASK  [NUM_SLOTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};
    localparam logic [7:0] SLOT_LO_MASK  [NUM_SLOTS] = '{8'hF8, 8'hF8, 8'hF8, 8'hFF};

    // field positions
    localparam int REF_BEMF_BIT  = 7;
    localparam int REF_CUR_BIT   = 6;
    localparam int REF_SEL_BIT   = 5;
    localparam int REF_MODE_LSB  = 3;
    localparam int REF_FREQ_LSB  = 0;
    localparam int CTRL_WIDTH_BIT = 7;
    localparam int CTRL_FULL_LSB = 4;
    localparam int CTRL_ALIGN_BIT = 3;
    localparam int CTRL_PRESC_LSB = 0;
    localparam int RUN_ENABLE_BIT = 0;

    localparam logic [7:0] REF_RESET  = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] REP_RESET  = 8'h00;

    // chopper half periods in controller clocks, one per frequency code
    localparam logic [5:0] CHOP_HALF [8] = '{6'h28, 6'h14, 6'h0A, 6'h08,
                                             6'h05, 6'h04, 6'h03, 6'h02};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] pre_hi;
        logic [7:0] pre_lo;
        logic       hi_done;
        logic       pair_done;
        logic [7:0] act_hi;
        logic [7:0] act_lo;
    } slot_state_t;

endpackage

/* File: rtl/three_phase_pwm_chopper.sv */
// Summary of operation
// R01: back-emf comparator output readable as status, 1 above reference.
// R02: current comparator output readable as status, 1 above current reference.
// R03: select bit 0 routes amplifier result, 1 routes external current input.
// R04: chop mode 00 off, 01 low side, 10 high side, 11 both.
// R05: three-bit code picks chopper frequency, 50 kHz to 1 MHz at 4 MHz.
// R06: chopper waveform has equal high and low times.
// R07: standard mode uses 13 compare bits; 8-bit mode uses high byte plus full-duty bit.
// R08: full-duty bit forces 100% for one update span, then clears itself.
// R09: alignment bit 0 edge-aligned counting, 1 center-aligned counting.
// R10: counter clock is controller clock divided by prescale code plus one.
// R11: repetition counter at zero transfers compares, flags update, reloads itself.
// R12: enabling the block copies repetition preload and flags an update.
// R13: repetition value written while running acts after the next update.
// R14: updates every N+1 periods edge-aligned, N+1 half periods centered.
// R15: phase compare is high byte plus low bits 7:3; low 2:0 reserved; resets zero.
// R16: compare 0 high keeps bits 3:0, bits 7:4 reserved, resets to 0Fh.
// R17: software writes high then low part before a compare can transfer.
// R18: reading a preloaded register returns its active value; the CTRL full-duty bits read back their preload value instead.
// R19: phase output active while counter below its compare value.
// R20: centered counter runs up to compare 0 then back down.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module three_phase_pwm_chopper #(
    parameter int CHOP_CNT_W = 6
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire pwm_chopper_pkg::reg_req_t  bus_req,
    output logic [pwm_chopper_pkg::DATA_W-1:0] rdata_r,
    input  wire logic                       bemf_cmp_in,
    input  wire logic                       amplifier_output,
    input  wire logic                       external_current_input,
    output logic                            current_input_select_r,
    output logic                            pwm_u_r,
    output logic                            pwm_v_r,
    output logic                            pwm_w_r,
    output logic                            chop_high_r,
    output logic                            chop_low_r,
    output logic                            update_event_r
);
    import pwm_chopper_pkg::*;

    initial begin
        if (CHOP_CNT_W < 6) begin
            $error("chopper counter too narrow for the longest half period");
        end
    end

    typedef struct packed {
        logic                  bemf_state;
        logic                  current_state;
        logic                  input_select;
        logic [1:0]            chop_mode;
        logic [2:0]            chop_frequency;
        logic                  compare_width_mode;
        logic [2:0]            full_pre;
        logic [2:0]            full_act;
        logic                  counter_alignment;
        logic [2:0]            counter_prescale;
        logic [7:0]            repeat_pre;
        logic [7:0]            repeat_act;
        logic [7:0]            repeat_cnt;
        logic                  enable;
        logic [2:0]            presc_cnt;
        logic [CNT_W-1:0]      cnt;
        logic                  count_down;
        logic [CHOP_CNT_W-1:0] chop_cnt;
        logic                  chop;
        logic [2:0]            pwm;
        logic                  chop_high;
        logic                  chop_low;
        logic                  update;
        logic [DATA_W-1:0]     rdata;
    } top_state_t;

    top_state_t s;
    top_state_t n;

    ////////////////////////////////////////////////////////////////////////////////
    // decode and compare slots

    logic                 wr_ref;
    logic                 wr_ctrl;
    logic                 wr_rep;
    logic                 wr_run;
    logic                 enable_rise;
    logic                 tick;
    logic                 boundary;
    logic                 upd;
    logic [CNT_W-1:0]     period;
    logic [7:0]           act_hi [NUM_SLOTS];
    logic [7:0]           act_lo [NUM_SLOTS];
    logic [CHOP_CNT_W-1:0] chop_half;

    assign wr_ref  = bus_req.wr && (bus_req.addr == ADDR_REF);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
    assign wr_rep  = bus_req.wr && (bus_req.addr == ADDR_REP);
    assign wr_run  = bus_req.wr && (bus_req.addr == ADDR_RUN);

    assign enable_rise = wr_run && bus_req.wdata[RUN_ENABLE_BIT] && !s.enable;  // R12

    assign period = {act_hi[SLOT_P0][3:0], act_lo[SLOT_P0]};

    // prescaler wraps at the code itself, so code k divides by k+1
    assign tick = s.enable && (s.presc_cnt == s.counter_prescale);              // R10

    // one boundary per period edge-aligned, per half period centered
    assign boundary = tick && ((s.counter_alignment && s.count_down) ?          // R14
                               (s.cnt == '0) : (s.cnt >= period));

    assign upd = enable_rise || (boundary && (s.repeat_cnt == 8'h00));          // R11

    assign chop_half = CHOP_CNT_W'(CHOP_HALF[s.chop_frequency]);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            compare_slot #(
                .HI_RESET (SLOT_HI_RESET[gi]),
                .LO_RESET (SLOT_LO_RESET[gi]),
                .HI_MASK  (SLOT_HI_MASK[gi]),
                .LO_MASK  (SLOT_LO_MASK[gi])
            ) u_slot (
                .clock  (clock),
                .rst    (rst),
                .wr_hi  (bus_req.wr && (bus_req.addr == SLOT_HI_ADDR[gi])),
                .wr_lo  (bus_req.wr && (bus_req.addr == SLOT_LO_ADDR[gi])),
                .wdata  (bus_req.wdata),
                .load   (upd),
                .act_hi (act_hi[gi]),
                .act_lo (act_lo[gi])
            );
        end
    endgenerate

    // extension bit: high byte bit 7 normally, the phase full-duty bit in 8-bit mode
    function automatic logic [CMP_W-1:0] phase_cmp(input logic [7:0] hi,
                                                   input logic [7:0] lo,
                                                   input logic       eight_bit,
                                                   input logic       ext);
        phase_cmp = eight_bit ? {ext, hi, 4'h0} : {hi, lo[7:3]};               // R07
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = s;

        // comparator status is sampled every cycle
        n.bemf_state    = bemf_cmp_in;                                          // R01
        n.current_state = s.input_select ? external_current_input             // R03
                                         : amplifier_output;                    // R02

        if (wr_ref) begin
            n.input_select   = bus_req.wdata[REF_SEL_BIT];
            n.chop_mode      = bus_req.wdata[REF_MODE_LSB +: 2];
            n.chop_frequency = bus_req.wdata[REF_FREQ_LSB +: 3];
        end

        // full-duty bits: hardware clears on transfer, a write in that cycle wins
        if (upd) begin
            n.full_act = s.full_pre;                                            // R08
            n.full_pre = 3'h0;
        end
        if (wr_ctrl) begin
            n.compare_width_mode = bus_req.wdata[CTRL_WIDTH_BIT];
            n.full_pre           = bus_req.wdata[CTRL_FULL_LSB +: 3];
            n.counter_alignment  = bus_req.wdata[CTRL_ALIGN_BIT];
            n.counter_prescale   = bus_req.wdata[CTRL_PRESC_LSB +: 3];
        end

        if (wr_rep) begin
            n.repeat_pre = bus_req.wdata;                                       // R13
        end
        if (upd) begin
            n.repeat_act = s.repeat_pre;                                        // R12
            n.repeat_cnt = s.repeat_pre;                                        // R11
        end else if (boundary) begin
            n.repeat_cnt = s.repeat_cnt - 8'h01;
        end

        if (wr_run) begin
            n.enable = bus_req.wdata[RUN_ENABLE_BIT];
        end

        // pwm counter
        if (!s.enable) begin
            n.presc_cnt  = 3'h0;
            n.cnt        = '0;
            n.count_down = 1'b0;
        end else if (!tick) begin
            n.presc_cnt = s.presc_cnt + 3'h1;
        end else begin
            n.presc_cnt = 3'h0;
            if (!s.counter_alignment) begin                                     // R09
                n.cnt = (s.cnt >= period) ? '0 : s.cnt + 12'h001;
            end else if (!s.count_down) begin
                if (s.cnt >= period) begin                                      // R20
                    // zero period parks the counter at zero
                    n.count_down = (period != '0);
                    n.cnt        = (period != '0) ? s.cnt - 12'h001 : '0;
                end else begin
                    n.cnt = s.cnt + 12'h001;
                end
            end else begin
                if (s.cnt == '0) begin
                    n.count_down = 1'b0;
                    n.cnt        = (period != '0) ? 12'h001 : '0;
                end else begin
                    n.cnt = s.cnt - 12'h001;
                end
            end
        end

        // chopper, toggled every half period; >= keeps a code change from stalling it
        if (!s.enable) begin
            n.chop_cnt = '0;
            n.chop     = 1'b0;
        end else if (s.chop_cnt >= chop_half - 6'h01) begin                    // R06
            n.chop_cnt = '0;
            n.chop     = !s.chop;                                               // R05
        end else begin
            n.chop_cnt = s.chop_cnt + 6'h01;
        end
        // gate is high where no chopping applies
        n.chop_low  = s.chop_mode[0] ? s.chop : 1'b1;                           // R04
        n.chop_high = s.chop_mode[1] ? s.chop : 1'b1;                           // R04

        for (int i = 0; i < NUM_PHASES; i++) begin
            n.pwm[i] = s.enable &&
                       (s.full_act[NUM_PHASES-1-i] ||                           // R08
                        ({1'b0, s.cnt} < phase_cmp(act_hi[i], act_lo[i],        // R19
                                                   s.compare_width_mode,
                                                   s.full_act[NUM_PHASES-1-i])));
        end

        n.update = upd;

        // read data stand for the one cycle after the strobe
        n.rdata = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_REF:  n.rdata = {s.bemf_state, s.current_state, s.input_select,
                                      s.chop_mode, s.chop_frequency};
                ADDR_CTRL: n.rdata = {s.compare_width_mode, s.full_pre,
                                      s.counter_alignment, s.counter_prescale};
                ADDR_REP:  n.rdata = s.repeat_act;                              // R18
                ADDR_UH:   n.rdata = act_hi[0];                                 // R18
                ADDR_UL:   n.rdata = act_lo[0];
                ADDR_VH:   n.rdata = act_hi[1];
                ADDR_VL:   n.rdata = act_lo[1];
                ADDR_WH:   n.rdata = act_hi[2];
                ADDR_WL:   n.rdata = act_lo[2];
                ADDR_P0H:  n.rdata = act_hi[SLOT_P0];
                ADDR_P0L:  n.rdata = act_lo[SLOT_P0];
                ADDR_RUN:  n.rdata = {7'h00, s.enable};
                default:   n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s                    <= '0;
            s.input_select       <= REF_RESET[REF_SEL_BIT];
            s.compare_width_mode <= CTRL_RESET[CTRL_WIDTH_BIT];
            s.repeat_pre         <= REP_RESET;
            s.repeat_act         <= REP_RESET;
            s.repeat_cnt         <= REP_RESET;
            s.chop_high          <= 1'b1;
            s.chop_low           <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign rdata_r                = s.rdata;
    assign current_input_select_r = s.input_select;
    assign pwm_u_r                = s.pwm[0];
    assign pwm_v_r                = s.pwm[1];
    assign pwm_w_r                = s.pwm[2];
    assign chop_high_r            = s.chop_high;
    assign chop_low_r             = s.chop_low;
    assign update_event_r         = s.update;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence enable_edge;
        wr_run && bus_req.wdata[RUN_ENABLE_BIT] && !s.enable;
    endsequence

    sequence slow_prescale;
        tick && s.counter_prescale == 3'h7 && !wr_ctrl && !wr_run;
    endsequence

    bemf_status_a: assert property (bus_req.rd && bus_req.addr == ADDR_REF |=> // R01
                                    rdata_r[REF_BEMF_BIT] == $past(s.bemf_state))
        else $error("back-emf status bit wrong");
    current_route_a: assert property (##1 s.current_state == ($past(s.input_select) ? // R03
                                      $past(external_current_input) : $past(amplifier_output)))
        else $error("current comparator source wrong");
    enable_update_a: assert property (enable_edge |=> update_event_r && // R12
                                      s.repeat_act == $past(s.repeat_pre))
        else $error("enable did not force an update");
    repeat_reload_a: assert property (upd |=> s.repeat_cnt == $past(s.repeat_pre)) // R11
        else $error("repetition counter not reloaded");
    repeat_hold_a: assert property (!upd && !wr_rep |=> $stable(s.repeat_act)) // R13
        else $error("repetition value changed without update");
    prescale_rate_a: assert property (slow_prescale ##1 (!wr_ctrl && !wr_run) [*7] |=> tick) // R10
        else $error("prescaler divisor wrong");
    edge_wrap_a: assert property (tick && !s.counter_alignment && s.cnt >= period |=> // R09
                                  s.cnt == '0)
        else $error("edge-aligned counter did not wrap");
    center_turn_a: assert property (tick && s.counter_alignment && !s.count_down && // R20
                                    s.cnt >= period && period != '0 |=> s.count_down)
        else $error("centered counter did not turn");
    full_duty_a: assert property (s.full_act[NUM_PHASES-1] && s.enable |=> pwm_u_r) // R08
        else $error("full duty not applied");
    full_clear_a: assert property (upd && !wr_ctrl |=> s.full_pre == 3'h0) // R08
        else $error("full-duty request not cleared");
    chop_toggle_a: assert property ($changed(s.chop) && s.enable |-> // R06
                                    $past(s.chop_cnt) >= $past(chop_half) - 6'h01 || !$past(s.enable))
        else $error("chopper toggled early");
    chop_off_a: assert property (s.chop_mode == 2'b00 |=> chop_high_r && chop_low_r) // R04
        else $error("chopper gate active while off");
    gate_low_a: assert property (s.chop_mode == 2'b10 |=> chop_low_r) // R04
        else $error("low side chopped in high-side mode");
    chop_idle_a: assert property (!s.enable |=> !s.chop) // R06
        else $error("chopper running while stopped");
    pwm_idle_a: assert property (!s.enable |=> !pwm_u_r && !pwm_v_r && !pwm_w_r) // R19
        else $error("phase output active while stopped");

endmodule

`default_nettype wire

/* File: testbench/power_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
    input  wire logic       clock,
    input  wire logic [2:0] level,
    output logic            bemf_cmp_in,
    output logic            amplifier_output,
    output logic            external_current_input
);
    // comparators settle on the clock, so the device never sees a mid-cycle change
    always_ff @(posedge clock) begin
        {bemf_cmp_in, amplifier_output, external_current_input} <= level;
    end
endmodule

`default_nettype wire

/* File: testbench/three_phase_pwm_chopper_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module three_phase_pwm_chopper_tb_top;
    import pwm_chopper_pkg::*;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    reg_req_t   bus_req = '0;
    logic [7:0] rdata_r;
    logic [2:0] level = 3'b000;
    logic       bemf, amp, ext, sel, pu, pv, pw, cg_hi, cg_lo, upd;
    int         n_mismatch = 0;
    int         cmp_count = 0;
    int         n, h, l, i, hv;
    localparam logic [7:0] RST_TAB [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                            8'h00, 8'h00, 8'h00, 8'h0F, 8'hFF};

    always #50 clock = ~clock;

    power_stage_model stage (.clock(clock), .level(level), .bemf_cmp_in(bemf),
        .amplifier_output(amp), .external_current_input(ext));
    three_phase_pwm_chopper uut (.clock(clock), .rst(rst), .bus_req(bus_req),
        .rdata_r(rdata_r), .bemf_cmp_in(bemf), .amplifier_output(amp),
        .external_current_input(ext), .current_input_select_r(sel), .pwm_u_r(pu),
        .pwm_v_r(pv), .pwm_w_r(pw), .chop_high_r(cg_hi), .chop_low_r(cg_lo),
        .update_event_r(upd));

    ////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata_r)
    endtask

    // bounded, so a dead update path ends as a mismatch, not a hang
    task wait_upd();
        #1;
        for (n = 0; n < 5000 && upd !== 1'b1; n++)
            @(posedge clock) #1;
    endtask

    // first gaps after a mode change may be partial, so only the third counts
    task gap_chk(input int e);
        wait_upd();
        repeat (2) begin
            @(posedge clock) #1;
            wait_upd();
        end
        `CHK("update gap", e, n + 1)
    endtask

    task highs(input int e_u, input int e_v);
        wait_upd();
        // the update cycle itself still shows the old duty
        @(posedge clock) #1;
        h = 0;
        l = 0;
        hv = 0;
        repeat (10) begin
            h += (pu === 1'b1);
            hv += (pv === 1'b1);
            l += (pw === 1'b1);
            @(posedge clock) #1;
        end
        `CHK("phase u highs", e_u, h)
        `CHK("phase v highs", e_v, hv)
        `CHK("phase w highs", 0, l)
    endtask

    task run_len(input logic v, output int c);
        for (c = 0; c < 200 && cg_lo === v; c++)
            @(posedge clock) #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 11; i++)
            rd(i[3:0], RST_TAB[i]);
        rd(4'hC, 8'h00);
        wr(ADDR_P0H, 8'hF0);
        wr(ADDR_P0L, 8'h09);
        wr(ADDR_UH, 8'h00);
        wr(ADDR_UL, 8'h2F);
        wr(ADDR_VH, 8'h00);
        wr(ADDR_VL, 8'h38);
        wr(ADDR_REP, 8'h01);
        wr(ADDR_RUN, 8'h01);
        rd(ADDR_P0H, 8'h00);
        rd(ADDR_UL, 8'h28);
        rd(ADDR_REP, 8'h01);
        gap_chk(20);
        wr(ADDR_REP, 8'h00);
        rd(ADDR_REP, 8'h01);
        wr(ADDR_WH, 8'h80);
        gap_chk(10);
        rd(ADDR_WH, 8'h00);
        highs(5, 7);
        wr(ADDR_CTRL, 8'h01);
        gap_chk(20);
        wr(ADDR_CTRL, 8'h07);
        gap_chk(80);
        wr(ADDR_CTRL, 8'h08);
        gap_chk(9);
        wr(ADDR_CTRL, 8'h80);
        highs(0, 0);
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_RUN, 8'h01);
        highs(10, 7);
        rd(ADDR_CTRL, 8'h00);
        highs(5, 7);
        for (i = 0; i < 4; i++) begin
            wr(ADDR_REF, {3'b000, i[1:0], 3'b111});
            repeat (3) @(posedge clock);
            #1;
            h = 0;
            l = 0;
            repeat (12) begin
                h += (cg_hi === 1'b1);
                l += (cg_lo === 1'b1);
                @(posedge clock) #1;
            end
            `CHK("high gate", i[1] ? 6 : 12, h)
            `CHK("low gate", i[0] ? 6 : 12, l)
        end
        for (i = 0; i < 8; i++) begin
            wr(ADDR_REF, {5'b00011, i[2:0]});
            run_len(1'b1, h);
            run_len(1'b0, l);
            run_len(1'b1, h);
            run_len(1'b0, l);
            `CHK("chop high", CHOP_HALF[i], h)
            `CHK("chop low", CHOP_HALF[i], l)
        end
        for (i = 0; i < 16; i++) begin
            level <= i[2:0];
            wr(ADDR_REF, {2'b00, i[3], 5'b00000});
            repeat (4) @(posedge clock);
            rd(ADDR_REF, {i[2], i[3] ? i[0] : i[1], i[3], 5'b00000});
            `CHK("input select", i[3], sel)
        end
        tally_and_finish();
    end

    initial begin
        #(100 * 20000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
